// ---- rtl/nmc_mode_regs.sv ----
// mode control register bank: operation, mode and bit rate registers
//
// Function
// - bit 7 powers oscillator and regulators
// - receive-on bit enables reception
// - one-channel bit picks single channel by pick
// - dual channel: auto or manual selection
// - transmit-on set by field-on, cleared after send in peer-to-peer modes only
// - wake-up bit enters wake-up mode
// - detector code selects off, thresholds or automatic
// - detector only set gives low power state
// - defaults load on every synchronous reset srst
// - role bit and four-bit code per role
// - initiator code decode, others reserved
// - unsupported code disables transmit and receive
// - target code decode for passive and active
// - target top bit runs bit rate detection
// - bit 2 picks keying or amplitude modulation
// - automatic response field code decode
// - mode writes only with stable crystal
// - bit rate fields, reserved bits zero
// - rate codes map to carrier divisors
`timescale 1ns/10ps
module nmc_mode_regs
    import nmc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire nmc_regbus_s bus,
    input  wire logic        xtal_stable_pin,
    input  wire logic        fixed_channel_pick,
    input  wire logic        field_on_cmd,
    input  wire logic        tx_done,
    output nmc_ctl_s         ctl,
    output logic [7:0]       rd_data,
    output logic             mode_wr_refused,
    output logic             osc_stable
);

    nmc_state_s s_q;
    nmc_state_s s_d;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] rate_div(input logic [1:0] code);
        rate_div = NMC_DIV_BASE >> code;
    endfunction

    function automatic nmc_opmode_e mode_decode(input logic [7:0] m);
        logic [3:0] om;
        om = m[NMC_MD_OM_HI:NMC_MD_OM_LO];
        mode_decode = NMC_M_NONE;
        if (m[NMC_MD_TARG]) begin
            if (om[NMC_OM_BRD]) begin
                mode_decode = NMC_M_T_BRD;
            end else if (om == NMC_OM_T_A) begin
                mode_decode = NMC_M_T_A;
            end else if (om == NMC_OM_T_F) begin
                mode_decode = NMC_M_T_F;
            end else if (om == NMC_OM_T_P2P) begin
                mode_decode = NMC_M_T_P2P;
            end
        end else begin
            unique case (om)
                NMC_OM_I_P2P:  mode_decode = NMC_M_I_P2P;
                NMC_OM_I_A:    mode_decode = NMC_M_I_A;
                NMC_OM_I_B:    mode_decode = NMC_M_I_B;
                NMC_OM_I_F:    mode_decode = NMC_M_I_F;
                NMC_OM_I_T1:   mode_decode = NMC_M_I_T1;
                NMC_OM_I_SUB:  mode_decode = NMC_M_I_SUB;
                NMC_OM_I_BPSK: mode_decode = NMC_M_I_BPSK;
                default:       mode_decode = NMC_M_NONE;
            endcase
        end
    endfunction

    function automatic nmc_ctl_s ctl_decode(input nmc_regs_s r,
                                            input logic      pick);
        nmc_ctl_s   c;
        logic       ok;
        logic [1:0] fd;
        logic [1:0] ar;
        c  = '0;
        fd = r.op[NMC_OP_FD_HI:NMC_OP_FD_LO];
        ar = r.mode[NMC_MD_AR_HI:NMC_MD_AR_LO];
        c.opmode       = mode_decode(r.mode);
        ok             = (c.opmode != NMC_M_NONE);
        c.txrx_disable = !ok;
        c.osc_reg_on   = r.op[NMC_OP_EN];
        c.rx_enable    = r.op[NMC_OP_RX_EN] && ok;
        c.tx_enable    = r.op[NMC_OP_TX_EN] && ok;
        if (r.op[NMC_OP_RX_ONE]) begin
            c.am_ch_on    = c.rx_enable && !pick;
            c.pm_ch_on    = c.rx_enable && pick;
            c.ch_auto_sel = 1'b0;
        end else begin
            c.am_ch_on    = c.rx_enable;
            c.pm_ch_on    = c.rx_enable;
            c.ch_auto_sel = !r.op[NMC_OP_RX_MAN];
        end
        c.wakeup_state_on = r.op[NMC_OP_WU];
        c.fd_enable    = (fd != NMC_FD_OFF);
        c.fd_thresh_ca = (fd == NMC_FD_CA) || (fd == NMC_FD_AUTO);
        c.fd_thresh_pd = (fd == NMC_FD_PD) || (fd == NMC_FD_AUTO);
        c.fd_auto      = (fd == NMC_FD_AUTO);
        c.low_power_init = (fd != NMC_FD_OFF) &&
            (r.op[NMC_OP_EN:NMC_OP_WU] == '0);
        c.role_target  = r.mode[NMC_MD_TARG];
        c.brd_detect_f = (c.opmode == NMC_M_T_BRD) &&
            r.mode[NMC_MD_OM_LO + NMC_OM_BRD_F];
        c.brd_detect_a = (c.opmode == NMC_M_T_BRD) &&
            r.mode[NMC_MD_OM_LO + NMC_OM_BRD_A];
        c.modulation_type = r.mode[NMC_MD_MOD];
        // reserved response code acts as off
        c.auto_resp_any      = (ar == NMC_AR_ANY);
        c.auto_resp_peer_off = (ar == NMC_AR_PEER);
        c.tx_rate_div = rate_div(r.rate[NMC_RT_TX_HI:NMC_RT_TX_LO]);
        c.rx_rate_div = rate_div(r.rate[NMC_RT_RX_HI:NMC_RT_RX_LO]);
        ctl_decode = c;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic active_mode;
    assign active_mode = (s_q.ctl.opmode == NMC_M_I_P2P) ||
                         (s_q.ctl.opmode == NMC_M_T_P2P);

    always_comb begin
        s_d = s_q;
        // three stage crystal flag sync, change once the last two stages agree
        s_d.osc_sync = {s_q.osc_sync[1:0], xtal_stable_pin};
        if (s_q.osc_sync[1] == s_q.osc_sync[2]) begin
            s_d.osc_ok = s_q.osc_sync[2];
        end
        s_d.mode_wr_refused = 1'b0;
        if (bus.wr) begin
            unique case (bus.addr)
                NMC_ADDR_OP:   s_d.regs.op = bus.wdata;
                NMC_ADDR_MODE: begin
                    if (s_q.osc_ok) begin
                        s_d.regs.mode = bus.wdata;
                    end else begin
                        s_d.mode_wr_refused = 1'b1;
                    end
                end
                NMC_ADDR_RATE: begin
                    s_d.regs.rate = bus.wdata & NMC_RATE_MASK;
                end
                default: ;
            endcase
        end
        // hardware set beats the clear after transmission
        if (tx_done && active_mode) begin
            s_d.regs.op[NMC_OP_TX_EN] = 1'b0;
        end
        if (field_on_cmd) begin
            s_d.regs.op[NMC_OP_TX_EN] = 1'b1;
        end
        s_d.rd_data = NMC_RD_NONE;
        if (bus.rd) begin
            unique case (bus.addr)
                NMC_ADDR_OP:   s_d.rd_data = s_q.regs.op;
                NMC_ADDR_MODE: s_d.rd_data = s_q.regs.mode;
                NMC_ADDR_RATE: s_d.rd_data = s_q.regs.rate;
                default:       s_d.rd_data = NMC_RD_NONE;
            endcase
        end
        if (srst) begin
            s_d.osc_sync        = '0;
            s_d.osc_ok          = 1'b0;
            s_d.regs.op         = NMC_OP_RST;
            s_d.regs.mode       = NMC_MODE_RST;
            s_d.regs.rate       = NMC_RATE_RST;
            s_d.rd_data         = NMC_RD_NONE;
            s_d.mode_wr_refused = 1'b0;
        end
        s_d.ctl = ctl_decode(s_d.regs, fixed_channel_pick);
    end

    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end

    assign ctl             = s_q.ctl;
    assign rd_data         = s_q.rd_data;
    assign mode_wr_refused = s_q.mode_wr_refused;
    assign osc_stable      = s_q.osc_ok;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_en_write;
        (bus.wr && bus.addr == NMC_ADDR_OP && !field_on_cmd)
            |=> (ctl.osc_reg_on == $past(bus.wdata[NMC_OP_EN]));
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable bit not applied");

    property p_rx_gate;
        ctl.rx_enable |-> (s_q.regs.op[NMC_OP_RX_EN] && !ctl.txrx_disable);
    endproperty
    a_rx_gate: assert property (p_rx_gate)
        else $error("receiver on without enable");

    property p_one_channel;
        (ctl.rx_enable && s_q.regs.op[NMC_OP_RX_ONE])
            |-> (ctl.am_ch_on != ctl.pm_ch_on);
    endproperty
    a_one_channel: assert property (p_one_channel)
        else $error("single channel mode has wrong channels");

    property p_tx_set;
        field_on_cmd |=> s_q.regs.op[NMC_OP_TX_EN];
    endproperty
    a_tx_set: assert property (p_tx_set)
        else $error("field on did not set transmit");

    property p_fd_enable;
        ctl.fd_enable == (s_q.regs.op[NMC_OP_FD_HI:NMC_OP_FD_LO] != '0);
    endproperty
    a_fd_enable: assert property (p_fd_enable)
        else $error("detector enable mismatch");

    property p_low_power;
        (bus.wr && bus.addr == NMC_ADDR_OP && !field_on_cmd)
            |=> (ctl.low_power_init == ($past(bus.wdata[NMC_OP_EN:
                NMC_OP_WU]) == '0 && $past(bus.wdata[NMC_OP_FD_HI:
                NMC_OP_FD_LO]) != '0));
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("low power state wrong");

    property p_disable;
        ctl.txrx_disable |-> (!ctl.tx_enable && !ctl.rx_enable);
    endproperty
    a_disable: assert property (p_disable)
        else $error("transmit or receive on with bad mode");

    property p_mode_guard;
        (bus.wr && bus.addr == NMC_ADDR_MODE && !osc_stable)
            |=> ($stable(s_q.regs.mode) && mode_wr_refused);
    endproperty
    a_mode_guard: assert property (p_mode_guard)
        else $error("mode written without stable crystal");

    property p_rate_rsv;
        (s_q.regs.rate & ~NMC_RATE_MASK) == '0;
    endproperty
    a_rate_rsv: assert property (p_rate_rsv)
        else $error("reserved rate bits set");

    property p_rate_div;
        (bus.wr && bus.addr == NMC_ADDR_RATE)
            |=> (ctl.tx_rate_div == (NMC_DIV_BASE >>
                $past(bus.wdata[NMC_RT_TX_HI:NMC_RT_TX_LO])));
    endproperty
    a_rate_div: assert property (p_rate_div)
        else $error("transmit divisor wrong");

endmodule // nmc_mode_regs

// ---- shared/nmc_pkg.sv ----
// constants, codes and carriers of the mode control register bank
package nmc_pkg;

    // ------------------------------------------------------------
    // register addresses and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] NMC_ADDR_OP    = 8'h02;
    localparam logic [7:0] NMC_ADDR_MODE  = 8'h03;
    localparam logic [7:0] NMC_ADDR_RATE  = 8'h04;
    localparam logic [7:0] NMC_OP_RST     = 8'h00;
    localparam logic [7:0] NMC_MODE_RST   = 8'h08;
    localparam logic [7:0] NMC_RATE_RST   = 8'h00;
    localparam logic [7:0] NMC_RATE_MASK  = 8'h33;
    localparam logic [7:0] NMC_RD_NONE    = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int NMC_OP_EN      = 7;
    localparam int NMC_OP_RX_EN   = 6;
    localparam int NMC_OP_RX_ONE  = 5;
    localparam int NMC_OP_RX_MAN  = 4;
    localparam int NMC_OP_TX_EN   = 3;
    localparam int NMC_OP_WU      = 2;
    localparam int NMC_OP_FD_HI   = 1;
    localparam int NMC_OP_FD_LO   = 0;
    localparam int NMC_MD_TARG    = 7;
    localparam int NMC_MD_OM_HI   = 6;
    localparam int NMC_MD_OM_LO   = 3;
    localparam int NMC_MD_MOD     = 2;
    localparam int NMC_MD_AR_HI   = 1;
    localparam int NMC_MD_AR_LO   = 0;
    localparam int NMC_RT_TX_HI   = 5;
    localparam int NMC_RT_TX_LO   = 4;
    localparam int NMC_RT_RX_HI   = 1;
    localparam int NMC_RT_RX_LO   = 0;
    localparam int NMC_OM_BRD     = 3;
    localparam int NMC_OM_BRD_F   = 2;
    localparam int NMC_OM_BRD_A   = 0;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [3:0] NMC_OM_I_P2P  = 4'h0;
    localparam logic [3:0] NMC_OM_I_A    = 4'h1;
    localparam logic [3:0] NMC_OM_I_B    = 4'h2;
    localparam logic [3:0] NMC_OM_I_F    = 4'h3;
    localparam logic [3:0] NMC_OM_I_T1   = 4'h4;
    localparam logic [3:0] NMC_OM_I_SUB  = 4'he;
    localparam logic [3:0] NMC_OM_I_BPSK = 4'hf;
    localparam logic [3:0] NMC_OM_T_A    = 4'h1;
    localparam logic [3:0] NMC_OM_T_F    = 4'h4;
    localparam logic [3:0] NMC_OM_T_P2P  = 4'h7;
    localparam logic [1:0] NMC_FD_OFF    = 2'h0;
    localparam logic [1:0] NMC_FD_CA     = 2'h1;
    localparam logic [1:0] NMC_FD_PD     = 2'h2;
    localparam logic [1:0] NMC_FD_AUTO   = 2'h3;
    localparam logic [1:0] NMC_AR_ANY    = 2'h1;
    localparam logic [1:0] NMC_AR_PEER   = 2'h2;
    localparam logic [7:0] NMC_DIV_BASE  = 8'h80;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        NMC_M_NONE   = 4'h0,
        NMC_M_I_P2P  = 4'h1,
        NMC_M_I_A    = 4'h2,
        NMC_M_I_B    = 4'h3,
        NMC_M_I_F    = 4'h4,
        NMC_M_I_T1   = 4'h5,
        NMC_M_I_SUB  = 4'h6,
        NMC_M_I_BPSK = 4'h7,
        NMC_M_T_A    = 4'h8,
        NMC_M_T_F    = 4'h9,
        NMC_M_T_P2P  = 4'ha,
        NMC_M_T_BRD  = 4'hb
    } nmc_opmode_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nmc_regbus_s;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] mode;
        logic [7:0] rate;
    } nmc_regs_s;

    typedef struct packed {
        logic        osc_reg_on;
        logic        rx_enable;
        logic        am_ch_on;
        logic        pm_ch_on;
        logic        ch_auto_sel;
        logic        tx_enable;
        logic        wakeup_state_on;
        logic        fd_enable;
        logic        fd_thresh_ca;
        logic        fd_thresh_pd;
        logic        fd_auto;
        logic        low_power_init;
        logic        role_target;
        nmc_opmode_e opmode;
        logic        txrx_disable;
        logic        brd_detect_f;
        logic        brd_detect_a;
        logic        modulation_type;
        logic        auto_resp_any;
        logic        auto_resp_peer_off;
        logic [7:0]  tx_rate_div;
        logic [7:0]  rx_rate_div;
    } nmc_ctl_s;

    typedef struct packed {
        logic [2:0] osc_sync;
        logic       osc_ok;
        nmc_regs_s  regs;
        nmc_ctl_s   ctl;
        logic [7:0] rd_data;
        logic       mode_wr_refused;
    } nmc_state_s;

endpackage

// ---- tb/nmc_host_model.sv ----
// host model driving the register strobe port of the mode register bank
`timescale 1ns/10ps
module nmc_host_model
    import nmc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        osc_stable,
    input  wire logic [7:0]  rd_data,
    input  wire logic        mode_wr_refused,
    output nmc_regbus_s      bus
);
    logic obey;

    initial begin
        bus  = '0;
        obey = 1'b1;
    end

    // ------------------------------------------------------------
    // bus cycles; any address is driven, the bench also uses unmapped 05
    // ------------------------------------------------------------
    // frame format register never touched here
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic refused);
        int n;
        n = 0;
        while (obey && a == NMC_ADDR_MODE && osc_stable !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        bus.wr    = 1'b1;
        bus.addr  = a;
        bus.wdata = (obey && a == NMC_ADDR_RATE) ? (d & NMC_RATE_MASK) : d;
        @(negedge mclk);
        bus.wr  = 1'b0;
        refused = mode_wr_refused;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        bus.rd   = 1'b1;
        bus.addr = a;
        @(negedge mclk);
        bus.rd = 1'b0;
        d      = rd_data;
    endtask
endmodule // nmc_host_model

// ---- tb/nmc_mode_regs_tb_top.sv ----
// self-checking bench of the mode control register bank
`timescale 1ns/10ps
module nmc_mode_regs_tb_top
    import nmc_pkg::*;
;
    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic [7:0]  rdx;
        logic [15:0] vx;
    } nmc_row_s;

    localparam nmc_row_s ROWS [25] = '{
        '{8'h02, 8'hc0, 8'hc0, 16'h00f8}, '{8'h02, 8'he0, 8'he0, 16'h00d0},
        '{8'h02, 8'hd0, 8'hd0, 16'h00f0}, '{8'h02, 8'h01, 8'h01, 16'h4003},
        '{8'h02, 8'h06, 8'h06, 16'h2006}, '{8'h02, 8'h83, 8'h83, 16'h1082},
        '{8'h02, 8'h08, 8'h08, 16'h8000}, '{8'h03, 8'h00, 8'h00, 16'h0008},
        '{8'h03, 8'h0c, 8'h0c, 16'h0014}, '{8'h03, 8'h11, 8'h11, 16'h001a},
        '{8'h03, 8'h1a, 8'h1a, 16'h0021}, '{8'h03, 8'h23, 8'h23, 16'h0028},
        '{8'h03, 8'h70, 8'h70, 16'h0030}, '{8'h03, 8'h78, 8'h78, 16'h0038},
        '{8'h03, 8'h28, 8'h28, 16'h0080}, '{8'h03, 8'h88, 8'h88, 16'h0040},
        '{8'h03, 8'ha0, 8'ha0, 16'h0048}, '{8'h03, 8'hb8, 8'hb8, 16'h0050},
        '{8'h03, 8'hc8, 8'hc8, 16'h0158}, '{8'h03, 8'hf0, 8'hf0, 16'h0258},
        '{8'h03, 8'h90, 8'h90, 16'h0080}, '{8'h04, 8'hff, 8'h33, 16'h1010},
        '{8'h04, 8'h21, 8'h21, 16'h2040}, '{8'h04, 8'h10, 8'h10, 16'h4080},
        '{8'h04, 8'hcc, 8'h00, 16'h8080}};
    localparam logic [7:0]  RSTV [3] = '{NMC_OP_RST, NMC_MODE_RST, NMC_RATE_RST};
    localparam logic [15:0] RSTW [3] = '{16'h0000, 16'h0010, 16'h8080};

    logic        mclk;
    logic        srst;
    logic        xtal_stable_pin;
    logic        fixed_channel_pick;
    logic        field_on_cmd;
    logic        tx_done;
    nmc_regbus_s bus;
    nmc_ctl_s    ctl;
    logic [7:0]  rd_data;
    logic        mode_wr_refused;
    logic        osc_stable;
    logic        refused;
    logic [7:0]  rv;
    int          failures;
    int          compares;
    int          cycles;

    nmc_mode_regs i_nmc_mode_regs (.mclk(mclk), .srst(srst), .bus(bus),
        .xtal_stable_pin(xtal_stable_pin), .fixed_channel_pick(fixed_channel_pick),
        .field_on_cmd(field_on_cmd), .tx_done(tx_done), .ctl(ctl),
        .rd_data(rd_data), .mode_wr_refused(mode_wr_refused),
        .osc_stable(osc_stable));

    nmc_host_model i_nmc_host_model (.mclk(mclk), .osc_stable(osc_stable),
        .rd_data(rd_data), .mode_wr_refused(mode_wr_refused), .bus(bus));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] view(input logic [7:0] a);
        logic r;
        r = ctl.rx_enable;
        case (a)
            NMC_ADDR_OP: view = {ctl.tx_enable, ctl.fd_thresh_ca & ~ctl.fd_auto,
                ctl.fd_thresh_pd & ~ctl.fd_auto, ctl.fd_auto, 4'h0,
                ctl.osc_reg_on, r, ctl.am_ch_on & r, ctl.pm_ch_on & r,
                ctl.ch_auto_sel & ctl.am_ch_on & ctl.pm_ch_on & r,
                ctl.wakeup_state_on, ctl.fd_enable, ctl.low_power_init};
            NMC_ADDR_MODE: view = {6'h0, ctl.brd_detect_f, ctl.brd_detect_a,
                ctl.txrx_disable, ctl.opmode, ctl.modulation_type,
                ctl.auto_resp_any, ctl.auto_resp_peer_off};
            default: view = {ctl.tx_rate_div, ctl.rx_rate_div};
        endcase
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_reset;
        for (int k = 0; k < 3; k++) begin
            i_nmc_host_model.rd(NMC_ADDR_OP + 8'(k), rv);
            chk({8'h0, rv}, {8'h0, RSTV[k]});
            chk(view(NMC_ADDR_OP + 8'(k)), RSTW[k]);
        end
    endtask

    task automatic pulse(input logic f);
        @(negedge mclk);
        field_on_cmd = f;
        tx_done      = ~f;
        @(negedge mclk);
        field_on_cmd = 1'b0;
        tx_done      = 1'b0;
    endtask

    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always #50 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        srst = 1'b1;
        xtal_stable_pin = 1'b0;
        fixed_channel_pick = 1'b1;
        field_on_cmd = 1'b0;
        tx_done = 1'b0;
        failures = 0;
        compares = 0;
        cycles = 0;
        repeat (6) @(negedge mclk);
        srst = 1'b0;
        check_reset();
        i_nmc_host_model.obey = 1'b0;
        i_nmc_host_model.wr(NMC_ADDR_MODE, 8'h00, refused);
        chk({15'h0, refused}, 16'h0001);
        i_nmc_host_model.rd(NMC_ADDR_MODE, rv);
        chk({8'h0, rv}, {8'h0, NMC_MODE_RST});
        i_nmc_host_model.obey = 1'b1;
        xtal_stable_pin = 1'b1;
        i_nmc_host_model.wr(NMC_ADDR_MODE, 8'h08, refused);
        chk({15'h0, refused}, 16'h0000);
        i_nmc_host_model.obey = 1'b0;
        foreach (ROWS[i]) begin
            i_nmc_host_model.wr(ROWS[i].addr, ROWS[i].wdata, refused);
            chk(view(ROWS[i].addr), ROWS[i].vx);
            i_nmc_host_model.rd(ROWS[i].addr, rv);
            chk({8'h0, rv}, {8'h0, ROWS[i].rdx});
        end
        i_nmc_host_model.wr(8'h05, 8'hff, refused);
        i_nmc_host_model.rd(8'h05, rv);
        chk({8'h0, rv}, 16'h0000);
        // transmit-on set by field-on, cleared after send only in peer modes
        i_nmc_host_model.wr(NMC_ADDR_MODE, 8'h00, refused);
        i_nmc_host_model.wr(NMC_ADDR_OP, 8'hc0, refused);
        pulse(1'b1);
        chk({15'h0, ctl.tx_enable}, 16'h0001);
        i_nmc_host_model.rd(NMC_ADDR_OP, rv);
        chk({8'h0, rv}, 16'h00c8);
        pulse(1'b0);
        chk({15'h0, ctl.tx_enable}, 16'h0000);
        i_nmc_host_model.wr(NMC_ADDR_MODE, 8'h28, refused);
        pulse(1'b1);
        chk({14'h0, ctl.tx_enable, ctl.rx_enable}, 16'h0000);
        i_nmc_host_model.wr(NMC_ADDR_MODE, 8'h08, refused);
        chk({15'h0, ctl.tx_enable}, 16'h0001);
        pulse(1'b0);
        chk({15'h0, ctl.tx_enable}, 16'h0001);
        @(negedge mclk);
        srst = 1'b1;
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        check_reset();
        final_report();
    end
endmodule // nmc_mode_regs_tb_top
